// >>> hw/mmc_control.sv
`timescale 1ns/1ns
`include "mmc_defines.svh"
module mmc_control
   import mmc_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = `MMC_INIT_CYC,
   parameter int unsigned SERIAL_CYCLES = `MMC_SERIAL_CYC
)
(
   input wire logic clock,
   input wire logic srst,
   input wire logic module_reset_n,
   input wire logic low_power_request,
   input wire logic module_select_n,
   input wire logic power_down_request,
   input wire mmc_flags_t flag_condition,
   input wire mmc_flags_t flag_mask,
   input wire logic flag_read_clear,
   input wire logic [6:0] bus_addr,
   output logic interrupt_out_n,
   output mmc_flags_t flags_out,
   output mmc_status_t status,
   output logic bus_addr_hit
);
   mmc_pins_t pins_raw;
   mmc_pins_t pins_q;
   logic rst_pin_q;
   logic lp_pin_q;
   logic sel_pin_n_q;

   mmc_state_t state_reg;
   mmc_state_t state_next;
   mmc_count_t init_cnt_reg;
   mmc_count_t init_cnt_next;
   logic [15:0] rst_low_reg;
   logic [15:0] rst_low_next;
   logic bus_ready_reg;
   logic bus_ready_next;
   logic init_done;
   logic reset_fire;

   mmc_flags_t flag_reg;
   mmc_flags_t flag_next;
   logic ready_flag_reg;
   logic ready_flag_next;
   logic dnr_reg;
   logic dnr_next;
   logic int_n_reg;
   logic int_n_next;
   mmc_status_t status_reg;
   mmc_status_t status_next;
   logic pending;

   // all three control pins arrive from the host asynchronously
   assign pins_raw[`MMC_PIN_RESET] = module_reset_n;
   assign pins_raw[`MMC_PIN_LOWPWR] = low_power_request;
   assign pins_raw[`MMC_PIN_SELECT] = module_select_n;

   mmc_pin_sync u_sync
   (
      .clock(clock),
      .srst(srst),
      .pin_in(pins_raw),
      .pin_out(pins_q)
   );

   assign rst_pin_q = pins_q[`MMC_PIN_RESET];
   assign lp_pin_q = pins_q[`MMC_PIN_LOWPWR];
   assign sel_pin_n_q = pins_q[`MMC_PIN_SELECT];

   // reset fires once the pin has stayed low for the minimum pulse width
   assign reset_fire = !rst_pin_q &&
      (rst_low_reg == 16'(`MMC_RESET_MIN_CYC)); // RULE2
   assign init_done = (state_reg == MMC_ST_INIT) &&
      (init_cnt_reg == mmc_count_t'(INIT_CYCLES - 1));

   // reset pulse width, init timer and management state
   always_comb
   begin
      state_next = state_reg;
      init_cnt_next = init_cnt_reg;
      rst_low_next = rst_low_reg;
      bus_ready_next = bus_ready_reg;
      if (rst_pin_q)
      begin
         rst_low_next = 16'h0000;
      end
      else if (rst_low_reg != 16'(`MMC_RESET_MIN_CYC))
      begin
         rst_low_next = rst_low_reg + 16'h0001; // RULE2
      end
      case (state_reg)
         MMC_ST_HOLD:
         begin
            init_cnt_next = 32'h00000000;
            bus_ready_next = 1'b0;
            if (rst_pin_q)
            begin
               state_next = MMC_ST_INIT; // RULE5
            end
         end
         MMC_ST_INIT:
         begin
            init_cnt_next = init_cnt_reg + 32'h00000001;
            if (init_cnt_reg >= mmc_count_t'(SERIAL_CYCLES - 1))
            begin
               bus_ready_next = 1'b1; // RULE3
            end
            if (init_done)
            begin
               state_next = MMC_ST_RUN; // RULE1
            end
         end
         MMC_ST_RUN:
         begin
            bus_ready_next = 1'b1;
         end
         default:
         begin
            state_next = MMC_ST_INIT;
            init_cnt_next = 32'h00000000;
         end
      endcase
      // a long enough low pulse wins over every state
      if (reset_fire)
      begin
         state_next = MMC_ST_HOLD; // RULE2
         bus_ready_next = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state_reg <= MMC_ST_INIT;
         init_cnt_reg <= 32'h00000000;
         rst_low_reg <= 16'h0000;
         bus_ready_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         init_cnt_reg <= init_cnt_next;
         rst_low_reg <= rst_low_next;
         bus_ready_reg <= bus_ready_next;
      end
   end

   // unmasked flags plus the ready event; mask takes effect at once
   assign pending = (|(flag_reg & ~flag_mask)) || ready_flag_reg; // RULE11

   // flags, ready event, data-not-ready and the interrupt line
   // the read-clear strobe comes from the serial engine at the falling
   // clock edge after the read's stop; a set in that cycle beats the clear
   always_comb
   begin
      flag_next = flag_reg;
      ready_flag_next = ready_flag_reg;
      dnr_next = dnr_reg;
      if (state_reg == MMC_ST_HOLD)
      begin
         flag_next = '0;
         ready_flag_next = 1'b0;
         dnr_next = 1'b1;
      end
      else
      begin
         flag_next = (flag_reg & ~{`MMC_NUM_FLAGS{flag_read_clear}}) |
            flag_condition; // RULE8 RULE9 RULE10 RULE17
         ready_flag_next = (ready_flag_reg & ~flag_read_clear) |
            init_done; // RULE4
         if (init_done)
         begin
            dnr_next = 1'b0; // RULE4
         end
      end
      int_n_next = !((state_reg != MMC_ST_HOLD) && pending); // RULE7 RULE12
   end

   // status; mask and power-down bits are taken as they arrive, the
   // write engine presents them after the write's stop
   always_comb
   begin
      status_next.fully_operational = (state_next == MMC_ST_RUN);
      status_next.data_not_ready = dnr_next;
      status_next.bus_respond = bus_ready_next && !sel_pin_n_q &&
         (state_next != MMC_ST_HOLD); // RULE13 RULE14
      status_next.low_power_active = lp_pin_q ||
         power_down_request; // RULE6 RULE15 RULE16 RULE18
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         flag_reg <= '0;
         ready_flag_reg <= 1'b0;
         dnr_reg <= 1'b1;
         int_n_reg <= 1'b1;
         status_reg <= 4'h4;
      end
      else
      begin
         flag_reg <= flag_next;
         ready_flag_reg <= ready_flag_next;
         dnr_reg <= dnr_next;
         int_n_reg <= int_n_next;
         status_reg <= status_next;
      end
   end

   assign interrupt_out_n = int_n_reg;
   assign flags_out = flag_reg;
   assign status = status_reg;
   // the address compare is combinational so the serial engine can ack
   assign bus_addr_hit = status_reg.bus_respond &&
      (bus_addr == `MMC_TWI_ADDR); // RULE19

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   property p_reset_pulse;
      reset_fire |=> (state_reg == MMC_ST_HOLD) && !status.bus_respond;
   endproperty
   a_reset_pulse: assert property (p_reset_pulse) else // RULE2
      $error("long reset pulse did not hold the module");

   property p_init_done;
      init_done && !reset_fire |=>
         (state_reg == MMC_ST_RUN) && !status.data_not_ready &&
         status.fully_operational ##1 !interrupt_out_n;
   endproperty
   a_init_done: assert property (p_init_done) else // RULE1 RULE4 RULE5
      $error("init end did not clear not-ready and raise interrupt");

   property p_release_init;
      (state_reg == MMC_ST_HOLD) && rst_pin_q |=>
         (state_reg == MMC_ST_INIT) && (init_cnt_reg == 32'h00000000);
   endproperty
   a_release_init: assert property (p_release_init) else // RULE5
      $error("reset release did not restart the init timer");

   property p_flag_set;
      (state_reg != MMC_ST_HOLD) && !reset_fire && (flag_condition != 0)
         |=> ((flag_reg & $past(flag_condition)) == $past(flag_condition))
         ##1 (!interrupt_out_n || $past(flag_mask) != 0 ||
         $past(state_reg) == MMC_ST_HOLD);
   endproperty
   a_flag_set: assert property (p_flag_set) else // RULE9 RULE10
      $error("condition did not set flag or interrupt");

   property p_int_assert;
      (state_reg != MMC_ST_HOLD) && pending |=> !interrupt_out_n;
   endproperty
   a_int_assert: assert property (p_int_assert) else // RULE7
      $error("pending source did not drive interrupt low");

   property p_read_release;
      flag_read_clear && (flag_condition == 0) && !init_done ##1
         (flag_condition == 0) |-> (flag_reg == 0) ##1 interrupt_out_n;
   endproperty
   a_read_release: assert property (p_read_release) else // RULE8 RULE17
      $error("read clear did not release interrupt");

   property p_mask_block;
      ((flag_reg & ~flag_mask) == 0) && !ready_flag_reg |=> interrupt_out_n;
   endproperty
   a_mask_block: assert property (p_mask_block) else // RULE11 RULE12
      $error("masked source still drives interrupt");

   property p_select;
      // a reset that fires inside the window legally drops the answer
      bus_ready_reg && (state_reg == MMC_ST_RUN) && !reset_fire ##1
         !sel_pin_n_q && !reset_fire ##1 !sel_pin_n_q
         |-> status.bus_respond;
   endproperty
   a_select: assert property (p_select) else // RULE13
      $error("selected module does not respond");

   property p_deselect;
      sel_pin_n_q |=> !status.bus_respond;
   endproperty
   a_deselect: assert property (p_deselect) else // RULE14
      $error("deselected module still responds");

   property p_power_down;
      (power_down_request || lp_pin_q) |=> status.low_power_active ##1
         (status.low_power_active || !$past(power_down_request) &&
         !$past(lp_pin_q));
   endproperty
   a_power_down: assert property (p_power_down) else // RULE6 RULE15
      $error("low power level not entered");

   property p_power_up;
      !power_down_request && !lp_pin_q |=> !status.low_power_active;
   endproperty
   a_power_up: assert property (p_power_up) else // RULE16 RULE18
      $error("low power level not left");

   c_run: cover property (init_done ##1 (state_reg == MMC_ST_RUN));
   c_hold: cover property (reset_fire ##1 (state_reg == MMC_ST_HOLD));
   c_int_clear: cover property (!interrupt_out_n ##1 flag_read_clear
      ##2 interrupt_out_n);
   c_addr_hit: cover property (bus_addr_hit);
endmodule

// >>> hw/mmc_defines.svh
`ifndef MMC_DEFINES_SVH
`define MMC_DEFINES_SVH
// What the document requires of this block and of its host
// RULE1: after power-on or reset release, become fully operational within 2000 ms.
// RULE2: reset pin low longer than 2 us resets; host holds it that long.
// RULE3: after power-on, answer the two-wire bus within 2000 ms.
// RULE4: within 2000 ms clear data-not-ready bit 0 byte 2, assert interrupt.
// RULE5: after reset pin rises, become fully operational within 2000 ms.
// RULE6: low-power input high enters lower power level within 100 us.
// RULE7: an interrupt condition drives the interrupt line low within 200 ms.
// RULE8: flags clear on read; interrupt line releases within 500 us after that.
// RULE9: receive loss-of-signal sets its flag and asserts interrupt within 100 ms.
// RULE10: any other condition sets its flag and asserts interrupt within 200 ms.
// RULE11: setting a mask bit stops that source interrupting within 100 ms.
// RULE12: clearing a mask bit resumes that source interrupting within 100 ms.
// RULE13: after module select asserts, answer the two-wire bus within 100 us.
// RULE14: after module select deasserts, stop answering the bus within 100 us.
// RULE15: power-down bit set enters lower power level within 100 ms.
// RULE16: power-down bit cleared returns to full operation within 300 ms.
// RULE17: read-clear timing starts at falling clock edge after the read's stop.
// RULE18: write timing starts at falling clock edge after the write's stop.
// RULE19: two-wire target address is 1010000 plus direction bit.
// RULE20: host keeps module select asserted during every transaction to the module.

// clock rate and documented times
`define MMC_CLK_MHZ 100
`define MMC_T_INIT_MS 2000
`define MMC_T_SERIAL_MS 2000
`define MMC_T_RESET_MIN_US 2

// derived cycle counts
`define MMC_RESET_MIN_CYC (`MMC_T_RESET_MIN_US * `MMC_CLK_MHZ)
`define MMC_INIT_CYC (`MMC_T_INIT_MS * 1000 * `MMC_CLK_MHZ)
`define MMC_SERIAL_CYC (`MMC_T_SERIAL_MS * 1000 * `MMC_CLK_MHZ)

// flag layout: low lanes are receive loss-of-signal
`define MMC_NUM_FLAGS 8
`define MMC_NUM_LOS 4

// two-wire target address, seven bits
`define MMC_TWI_ADDR 7'h50

// positions in the synchronised pin vector and their reset values
`define MMC_NUM_PINS 3
`define MMC_PIN_RESET 0
`define MMC_PIN_LOWPWR 1
`define MMC_PIN_SELECT 2
`define MMC_PIN_RST_VAL 3'h5
`endif

// >>> hw/mmc_pin_sync.sv
`timescale 1ns/1ns
`include "mmc_defines.svh"
module mmc_pin_sync
   import mmc_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire mmc_pins_t pin_in,
   output mmc_pins_t pin_out
);
   mmc_pins_t s1_reg;
   mmc_pins_t s2_reg;
   mmc_pins_t s3_reg;
   mmc_pins_t out_reg;
   mmc_pins_t out_next;

   // a change counts only once stages two and three agree, which filters
   // a single metastable sample out of the result
   genvar i;
   generate
      for (i = 0; i < `MMC_NUM_PINS; i = i + 1)
      begin : g_pin
         always_comb
         begin
            out_next[i] = out_reg[i];
            if (s2_reg[i] == s3_reg[i])
            begin
               out_next[i] = s3_reg[i];
            end
         end
      end
   endgenerate

   // shift chain; stage one feeds only stage two
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s1_reg <= `MMC_PIN_RST_VAL;
         s2_reg <= `MMC_PIN_RST_VAL;
         s3_reg <= `MMC_PIN_RST_VAL;
         out_reg <= `MMC_PIN_RST_VAL;
      end
      else
      begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         out_reg <= out_next;
      end
   end

   assign pin_out = out_reg;
endmodule

// >>> hw/mmc_pkg.sv
`include "mmc_defines.svh"
package mmc_pkg;
   // management state: held in reset, initialising, running
   typedef enum logic [1:0]
   {
      MMC_ST_HOLD = 2'b00,
      MMC_ST_INIT = 2'b01,
      MMC_ST_RUN = 2'b10
   } mmc_state_t;

   typedef logic [`MMC_NUM_FLAGS-1:0] mmc_flags_t;
   typedef logic [31:0] mmc_count_t;
   typedef logic [`MMC_NUM_PINS-1:0] mmc_pins_t;

   // status bits that leave the block together
   typedef struct packed
   {
      logic fully_operational;
      logic data_not_ready;
      logic bus_respond;
      logic low_power_active;
   } mmc_status_t;
endpackage

// >>> tb/mmc_host_model.sv
`timescale 1ns/1ns
// host side of the management pins: reset, low power, select, read strobe
module mmc_host_model
(
   input wire logic clock,
   output logic module_reset_n,
   output logic low_power_request,
   output logic module_select_n,
   output logic flag_read_clear,
   output logic [6:0] bus_addr
);
   // idle host: out of reset, full power, deselected
   initial
   begin
      module_reset_n = 1'b1;
      low_power_request = 1'b0;
      module_select_n = 1'b1;
      flag_read_clear = 1'b0;
      bus_addr = 7'h2A;
   end
   // the bench sets the low time, either side of the minimum width
   task automatic set_reset(input logic v);
      @(negedge clock);
      module_reset_n = v;
   endtask
   task automatic set_lp(input logic v);
      @(negedge clock);
      low_power_request = v;
   endtask
   // select stays low across every address phase but the last one in t_select, which sees it drop
   task automatic set_select(input logic v);
      @(negedge clock);
      module_select_n = ~v;
   endtask
   task automatic address(input logic [6:0] a);
      @(negedge clock);
      bus_addr = a;
      // let the combinational address compare settle before anyone looks
      #1;
   endtask
   // released bus shows the inverse, so a stale address never matches
   task automatic release_bus();
      @(negedge clock);
      bus_addr = ~bus_addr;
   endtask
   // one-cycle strobe, as the serial engine gives after a read stop
   task automatic read_clear();
      @(negedge clock);
      flag_read_clear = 1'b1;
      @(negedge clock);
      flag_read_clear = 1'b0;
   endtask
endmodule

// >>> tb/module_mgmt_control_timing_bench.sv
`timescale 1ns/1ns
module module_mgmt_control_timing_bench;
   import mmc_pkg::*;
   // short counts keep the run brief; serial ready must not exceed init
   localparam int INIT = 50;
   localparam int SER = 40;
   logic clock;
   logic srst;
   logic power_down_request;
   mmc_flags_t flag_condition;
   mmc_flags_t flag_mask;
   logic module_reset_n, low_power_request, module_select_n;
   logic flag_read_clear, interrupt_out_n, bus_addr_hit;
   logic [6:0] bus_addr;
   mmc_flags_t flags_out;
   mmc_status_t status;
   int errors = 0;
   int total_checks = 0;

   always #5 clock = ~clock;

   mmc_host_model u_host
   (
      .clock(clock),
      .module_reset_n(module_reset_n),
      .low_power_request(low_power_request),
      .module_select_n(module_select_n),
      .flag_read_clear(flag_read_clear),
      .bus_addr(bus_addr)
   );

   mmc_control #(.INIT_CYCLES(INIT), .SERIAL_CYCLES(SER)) u_dut
   (
      .clock(clock),
      .srst(srst),
      .module_reset_n(module_reset_n),
      .low_power_request(low_power_request),
      .module_select_n(module_select_n),
      .power_down_request(power_down_request),
      .flag_condition(flag_condition),
      .flag_mask(flag_mask),
      .flag_read_clear(flag_read_clear),
      .bus_addr(bus_addr),
      .interrupt_out_n(interrupt_out_n),
      .flags_out(flags_out),
      .status(status),
      .bus_addr_hit(bus_addr_hit)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   function automatic logic pick(input int k);
      case (k)
         0: return interrupt_out_n;
         1: return status.fully_operational;
         2: return status.bus_respond;
         default: return status.low_power_active;
      endcase
   endfunction

   // bounded wait; running out of cycles ends the run as a failure
   task automatic wait_on(input int k, input logic v, input int n);
      for (int i = 0; i < n && pick(k) !== v; i++)
         @(negedge clock);
      if (pick(k) !== v)
      begin
         check(8'(pick(k)), 8'(v));
         test_done();
      end
   endtask

   task automatic clear_all();
      flag_condition = 8'h00;
      u_host.read_clear();
      wait_on(0, 1'b1, 4);
   endtask

   // ready must not come early, then arrives and its interrupt follows a cycle later
   task automatic t_init();
      repeat (INIT - 3) @(negedge clock);
      check(8'(status.fully_operational), 8'h00);
      wait_on(1, 1'b1, 6);
      check(8'(status.data_not_ready), 8'h00);
      wait_on(0, 1'b0, 3);
      clear_all();
   endtask

   // walk every flag, receive-loss lanes first, then the others
   task automatic t_flags();
      for (int i = 0; i < 8; i++)
      begin
         flag_condition = 8'h01 << i;
         @(negedge clock);
         check(flags_out, 8'h01 << i);
         @(negedge clock);
         check(8'(interrupt_out_n), 8'h00);
         clear_all();
         check(flags_out, 8'h00);
      end
   endtask

   task automatic t_mask();
      flag_condition = 8'h40;
      repeat (3) @(negedge clock);
      check(8'(interrupt_out_n), 8'h00);
      flag_mask = 8'h40;
      repeat (2) @(negedge clock);
      check(8'(interrupt_out_n), 8'h01);
      check(flags_out, 8'h40);
      flag_mask = 8'h00;
      repeat (2) @(negedge clock);
      check(8'(interrupt_out_n), 8'h00);
      clear_all();
   endtask

   // select gates answers; only the one target address hits
   task automatic t_select();
      u_host.set_select(1'b1);
      wait_on(2, 1'b1, 8);
      u_host.address(7'h50);
      check(8'(bus_addr_hit), 8'h01);
      u_host.address(7'h51);
      check(8'(bus_addr_hit), 8'h00);
      u_host.address(7'h50);
      u_host.set_select(1'b0);
      wait_on(2, 1'b0, 8);
      check(8'(bus_addr_hit), 8'h00);
      u_host.release_bus();
   endtask

   task automatic t_power();
      u_host.set_lp(1'b1);
      wait_on(3, 1'b1, 8);
      u_host.set_lp(1'b0);
      wait_on(3, 1'b0, 8);
      power_down_request = 1'b1;
      @(negedge clock);
      check(8'(status.low_power_active), 8'h01);
      power_down_request = 1'b0;
      @(negedge clock);
      check(8'(status.low_power_active), 8'h00);
      check(8'(status.fully_operational), 8'h01);
   endtask

   // a short pulse is ignored; a long one resets and reinitialises
   task automatic t_reset();
      u_host.set_select(1'b1);
      u_host.set_reset(1'b0);
      repeat (20) @(negedge clock);
      u_host.set_reset(1'b1);
      repeat (30) @(negedge clock);
      check(8'(status.fully_operational), 8'h01);
      u_host.set_reset(1'b0);
      repeat (190) @(negedge clock);
      check(8'(status.fully_operational), 8'h01);
      wait_on(1, 1'b0, 30);
      @(negedge clock);
      check(8'(status), 8'h04);
      u_host.set_reset(1'b1);
      repeat (SER - 5) @(negedge clock);
      check(8'(status.bus_respond), 8'h00);
      wait_on(2, 1'b1, 12);
      wait_on(1, 1'b1, INIT - SER + 10);
      wait_on(0, 1'b0, 3);
      clear_all();
      u_host.set_select(1'b0);
   endtask

   // idle stimulus; t_flags, t_mask and t_power drive these away from rest
   initial
   begin
      clock = 1'b0;
      srst = 1'b1;
      power_down_request = 1'b0;
      flag_condition = 8'h00;
      flag_mask = 8'h00;
      repeat (2) @(negedge clock);
      srst = 1'b0;
      check(8'(status), 8'h04);
      t_init();
      t_flags();
      t_mask();
      t_select();
      t_power();
      t_reset();
      test_done();
   end
endmodule
